/* File: src/pal_pkg.sv */
// package of constants for the three-channel process alarm block
// Functional notes
// - source per alarm: off, process, band, deviation
// - high type asserts above threshold
// - low type asserts below threshold, even at start
// - inhibited low masked until value first exceeds threshold
// - clearing needs threshold passed by hysteresis amount
// - hysteresis settable from 0.1 to 10 percent
// - input averaged over window, off to 5 s
// - auto reset self-clears; latching waits operator reset
// - fail-safe relay energized while healthy
// - direct relay energized only while alarmed
// - threshold in full-scale units, up to 110 percent
// - alarm one defaults inhibited low, 5 percent
// - alarm two defaults high at 60 percent
// - alarm three defaults high at 80 percent
// - mask re-arm only for inhibited low alarms
package pal_pkg;
  localparam int unsigned NUM_ALARMS = 3;
  // byte offsets
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_CFG2 = 8'h08;
  localparam logic [7:0] ADDR_THR0 = 8'h0c;
  localparam logic [7:0] ADDR_THR1 = 8'h10;
  localparam logic [7:0] ADDR_THR2 = 8'h14;
  localparam logic [7:0] ADDR_SETPOINT = 8'h18;
  localparam logic [7:0] ADDR_FULLSCALE = 8'h1c;
  localparam logic [7:0] ADDR_CMD = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h30;
  // config field positions
  localparam int unsigned CFG_SRC_LSB = 0;
  localparam int unsigned CFG_TYP_LSB = 2;
  localparam int unsigned CFG_RST_BIT = 4;
  localparam int unsigned CFG_POL_BIT = 5;
  localparam int unsigned CFG_FILT_LSB = 8;
  localparam int unsigned CFG_HYST_LSB = 16;
  // command and status field positions
  localparam int unsigned CMD_ACK_LSB = 0;
  localparam int unsigned CMD_REARM_LSB = 4;
  localparam int unsigned STAT_ALARM_LSB = 0;
  localparam int unsigned STAT_COND_LSB = 4;
  localparam int unsigned STAT_MASK_LSB = 8;
  // encodings
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_PROC = 2'h1;
  localparam logic [1:0] SRC_BAND = 2'h2;
  localparam logic [1:0] SRC_DEVIATION = 2'h3;
  localparam logic [1:0] TYP_HIGH = 2'h0;
  localparam logic [1:0] TYP_LOW = 2'h1;
  localparam logic [1:0] TYP_INHIB = 2'h2;
  localparam logic RST_AUTO = 1'h0;
  localparam logic RST_LATCH = 1'h1;
  localparam logic RELAY_FAIL_SAFE = 1'h0;
  localparam logic RELAY_DIRECT = 1'h1;
  // hysteresis in 0.1 percent steps, filter window in 0.1 s steps
  localparam logic [6:0] HYST_MIN = 7'h01;
  localparam logic [6:0] HYST_MAX = 7'h64;
  localparam logic [22:0] HYST_DIV = 23'h0003e8;
  localparam int unsigned FILT_STEP_MS = 100;
  localparam logic [5:0] FILT_MAX = 6'h32;
  localparam logic [17:0] THR_MAX_NUM = 18'h0000b;
  localparam logic [19:0] THR_MAX_DEN = 20'h0000a;
  // reset values
  localparam logic [15:0] FULLSCALE_RST = 16'h2710;
  localparam logic [15:0] THR0_RST = 16'h01f4;
  localparam logic [15:0] THR1_RST = 16'h1770;
  localparam logic [15:0] THR2_RST = 16'h1f40;
  localparam logic [5:0] FILT_RST = 6'h04;
  localparam logic [6:0] HYST_RST = 7'h0a;
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
endpackage

/* File: src/pal_alarm_core.sv */
// three process alarms with filter, hysteresis, latching, relay drive and apb registers
`timescale 1ns/1ps
`default_nettype none
module pal_alarm_core #(
  parameter int unsigned SAMPLES_PER_TENTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] measValue,
  input wire logic measValid,
  input wire logic [15:0] controlSetpoint,
  output logic [2:0] relayDrive,
  output logic irq
);

  generate
    if (SAMPLES_PER_TENTH < 1 || SAMPLES_PER_TENTH > 1000) begin : gBadParam
      $error("SAMPLES_PER_TENTH must be 1 to 1000");
    end
  endgenerate

  typedef struct packed {
    logic [2:0][1:0] src;
    logic [2:0][1:0] typ;
    logic [2:0] rstMode;
    logic [2:0] polarity;
    logic [2:0][5:0] filtWin;
    logic [2:0][6:0] hyst;
    logic [2:0][15:0] thr;
    logic [15:0] fullScale;
    logic [2:0][23:0] filt;
    logic [2:0] cond;
    logic [2:0] masked;
    logic [2:0] alarm;
    logic [2:0] relay;
    logic [2:0] irqStat;
    logic [2:0] irqEn;
    logic [31:0] rdData;
  } pal_state_t;

  pal_state_t s_reg;
  pal_state_t s_next;

  // exponential filter shift: floor(log2(samples in window + 1))
  function automatic logic [3:0] pal_win_shift(input logic [5:0] win);
    logic [15:0] n;
    logic [3:0] sh;
    n = 16'(win * SAMPLES_PER_TENTH) + 16'h0001;
    sh = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (n >= 16'(1 << i)) begin
        sh = 4'(i);
      end
    end
    return sh;
  endfunction

  logic setupRd;
  logic accWr;
  logic mapped;

  assign pready = penable;
  assign setupRd = psel & ~penable & ~pwrite;
  assign accWr = psel & penable & pwrite;
  assign prdata = s_reg.rdData;
  assign relayDrive = s_reg.relay;
  assign irq = |(s_reg.irqStat & s_reg.irqEn);
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      pal_pkg::ADDR_CFG0, pal_pkg::ADDR_CFG1, pal_pkg::ADDR_CFG2,
      pal_pkg::ADDR_THR0, pal_pkg::ADDR_THR1, pal_pkg::ADDR_THR2,
      pal_pkg::ADDR_SETPOINT, pal_pkg::ADDR_FULLSCALE, pal_pkg::ADDR_CMD,
      pal_pkg::ADDR_STATUS, pal_pkg::ADDR_IRQ_STATUS, pal_pkg::ADDR_IRQ_ENABLE,
      pal_pkg::ADDR_IRQ_CLEAR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    logic [24:0] fdiff;
    logic [17:0] value;
    logic [17:0] sdiff;
    logic [17:0] thrS;
    logic [22:0] hProd;
    logic [17:0] hAmt;
    logic [35:0] thrMax;
    logic [2:0] ack;
    logic [2:0] rearm;
    logic [2:0] irqClr;
    logic [2:0] rise;
    logic active;
    logic [5:0] winW;
    logic [6:0] hystW;
    logic [31:0] rd;
    fdiff = 25'h0000000;
    value = 18'h00000;
    sdiff = 18'h00000;
    thrS = 18'h00000;
    hProd = 23'h000000;
    hAmt = 18'h00000;
    thrMax = (36'(s_reg.fullScale) * 36'(pal_pkg::THR_MAX_NUM)) / 36'(pal_pkg::THR_MAX_DEN);
    ack = 3'h0;
    rearm = 3'h0;
    irqClr = 3'h0;
    rise = 3'h0;
    active = 1'b0;
    winW = pwdata[pal_pkg::CFG_FILT_LSB +: 6];
    hystW = pwdata[pal_pkg::CFG_HYST_LSB +: 7];
    rd = 32'h00000000;
    s_next = s_reg;

    // register writes
    if (accWr) begin
      case (paddr)
        pal_pkg::ADDR_CMD: begin
          ack = pwdata[pal_pkg::CMD_ACK_LSB +: 3];
          rearm = pwdata[pal_pkg::CMD_REARM_LSB +: 3];
        end
        pal_pkg::ADDR_SETPOINT: ;
        pal_pkg::ADDR_FULLSCALE: s_next.fullScale = pwdata[15:0];
        pal_pkg::ADDR_IRQ_ENABLE: s_next.irqEn = pwdata[2:0];
        pal_pkg::ADDR_IRQ_CLEAR: irqClr = pwdata[2:0];
        default: ;
      endcase
      for (int a = 0; a < 3; a++) begin
        if (paddr == pal_pkg::ADDR_CFG0 + 8'(4 * a)) begin
          s_next.src[a] = pwdata[pal_pkg::CFG_SRC_LSB +: 2];
          s_next.typ[a] = (pwdata[pal_pkg::CFG_TYP_LSB +: 2] == 2'h3) ?
                          pal_pkg::TYP_HIGH : pwdata[pal_pkg::CFG_TYP_LSB +: 2];
          s_next.rstMode[a] = pwdata[pal_pkg::CFG_RST_BIT];
          s_next.polarity[a] = pwdata[pal_pkg::CFG_POL_BIT];
          s_next.filtWin[a] = (winW > pal_pkg::FILT_MAX) ? pal_pkg::FILT_MAX : winW;
          if (hystW < pal_pkg::HYST_MIN) begin
            s_next.hyst[a] = pal_pkg::HYST_MIN;
          end else if (hystW > pal_pkg::HYST_MAX) begin
            s_next.hyst[a] = pal_pkg::HYST_MAX;
          end else begin
            s_next.hyst[a] = hystW;
          end
          if (s_next.typ[a] == pal_pkg::TYP_INHIB && s_reg.typ[a] != pal_pkg::TYP_INHIB) begin
            s_next.masked[a] = 1'b1;
          end
        end
        if (paddr == pal_pkg::ADDR_THR0 + 8'(4 * a)) begin
          s_next.thr[a] = (36'(pwdata[15:0]) > thrMax) ? thrMax[15:0] : pwdata[15:0];
        end
      end
    end

    // per-alarm evaluation
    for (int a = 0; a < 3; a++) begin
      if (measValid) begin
        fdiff = 25'({1'b0, measValue, 8'h00}) - 25'({1'b0, s_reg.filt[a]});
        s_next.filt[a] = s_reg.filt[a] +
                         24'($signed(fdiff) >>> pal_win_shift(s_reg.filtWin[a]));
        sdiff = 18'({2'b00, s_next.filt[a][23:8]}) - 18'({2'b00, controlSetpoint});
        case (s_reg.src[a])
          pal_pkg::SRC_BAND: value = sdiff[17] ? 18'(-$signed(sdiff)) : sdiff;
          pal_pkg::SRC_DEVIATION: value = sdiff;
          default: value = 18'({2'b00, s_next.filt[a][23:8]});
        endcase
        thrS = 18'({2'b00, s_reg.thr[a]});
        hProd = 23'(s_reg.fullScale) * 23'(s_reg.hyst[a]);
        hAmt = 18'(hProd / pal_pkg::HYST_DIV);
        if (s_reg.src[a] == pal_pkg::SRC_OFF) begin
          s_next.cond[a] = 1'b0;
        end else if (s_reg.typ[a] == pal_pkg::TYP_HIGH) begin
          if (!s_reg.cond[a] && $signed(value) > $signed(thrS)) begin
            s_next.cond[a] = 1'b1;
          end else if (s_reg.cond[a] && $signed(value) < $signed(thrS - hAmt)) begin
            s_next.cond[a] = 1'b0;
          end
        end else begin
          if (!s_reg.cond[a] && $signed(value) < $signed(thrS)) begin
            s_next.cond[a] = 1'b1;
          end else if (s_reg.cond[a] && $signed(value) > $signed(thrS + hAmt)) begin
            s_next.cond[a] = 1'b0;
          end
          if (s_reg.typ[a] == pal_pkg::TYP_INHIB && $signed(value) > $signed(thrS)) begin
            s_next.masked[a] = 1'b0;
          end
          // no condition builds up while masked, so unmasking never trips at once
          if (s_reg.typ[a] == pal_pkg::TYP_INHIB && s_next.masked[a]) begin
            s_next.cond[a] = 1'b0;
          end
        end
      end
      if (rearm[a] && s_reg.typ[a] == pal_pkg::TYP_INHIB) begin
        s_next.masked[a] = 1'b1;
      end
      // config writes take effect on the write edge itself
      active = s_next.cond[a] & ~(s_next.masked[a] & (s_next.typ[a] == pal_pkg::TYP_INHIB));
      if (s_next.src[a] == pal_pkg::SRC_OFF) begin
        s_next.alarm[a] = 1'b0;
      end else if (s_next.rstMode[a] == pal_pkg::RST_AUTO) begin
        s_next.alarm[a] = active;
      end else begin
        s_next.alarm[a] = active | (s_reg.alarm[a] & ~ack[a]);
      end
      rise[a] = s_next.alarm[a] & ~s_reg.alarm[a];
      if (s_next.polarity[a] == pal_pkg::RELAY_FAIL_SAFE) begin
        s_next.relay[a] = ~s_next.alarm[a];
      end else begin
        s_next.relay[a] = s_next.alarm[a];
      end
    end

    // sticky events, set wins over clear
    s_next.irqStat = (s_reg.irqStat & ~irqClr) | rise;

    // read data captured in the setup cycle
    case (paddr)
      pal_pkg::ADDR_SETPOINT: rd = {16'h0000, controlSetpoint};
      pal_pkg::ADDR_FULLSCALE: rd = {16'h0000, s_reg.fullScale};
      pal_pkg::ADDR_STATUS: begin
        rd[pal_pkg::STAT_ALARM_LSB +: 3] = s_reg.alarm;
        rd[pal_pkg::STAT_COND_LSB +: 3] = s_reg.cond;
        rd[pal_pkg::STAT_MASK_LSB +: 3] = s_reg.masked;
      end
      pal_pkg::ADDR_IRQ_STATUS: rd = {29'h00000000, s_reg.irqStat};
      pal_pkg::ADDR_IRQ_ENABLE: rd = {29'h00000000, s_reg.irqEn};
      default: rd = 32'h00000000;
    endcase
    for (int a = 0; a < 3; a++) begin
      if (paddr == pal_pkg::ADDR_CFG0 + 8'(4 * a)) begin
        rd[pal_pkg::CFG_SRC_LSB +: 2] = s_reg.src[a];
        rd[pal_pkg::CFG_TYP_LSB +: 2] = s_reg.typ[a];
        rd[pal_pkg::CFG_RST_BIT] = s_reg.rstMode[a];
        rd[pal_pkg::CFG_POL_BIT] = s_reg.polarity[a];
        rd[pal_pkg::CFG_FILT_LSB +: 6] = s_reg.filtWin[a];
        rd[pal_pkg::CFG_HYST_LSB +: 7] = s_reg.hyst[a];
      end
      if (paddr == pal_pkg::ADDR_THR0 + 8'(4 * a)) begin
        rd = {16'h0000, s_reg.thr[a]};
      end
    end
    if (setupRd) begin
      s_next.rdData = rd;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_reg.src <= {3{pal_pkg::SRC_PROC}};
      s_reg.typ <= {pal_pkg::TYP_HIGH, pal_pkg::TYP_HIGH, pal_pkg::TYP_INHIB};
      s_reg.rstMode <= {3{pal_pkg::RST_AUTO}};
      s_reg.polarity <= {3{pal_pkg::RELAY_FAIL_SAFE}};
      s_reg.filtWin <= {3{pal_pkg::FILT_RST}};
      s_reg.hyst <= {3{pal_pkg::HYST_RST}};
      s_reg.thr <= {pal_pkg::THR2_RST, pal_pkg::THR1_RST, pal_pkg::THR0_RST};
      s_reg.fullScale <= pal_pkg::FULLSCALE_RST;
      s_reg.filt <= {3{24'h000000}};
      s_reg.cond <= 3'h0;
      s_reg.masked <= 3'h7;
      s_reg.alarm <= 3'h0;
      s_reg.relay <= 3'h7;
      s_reg.irqStat <= 3'h0;
      s_reg.irqEn <= 3'h0;
      s_reg.rdData <= 32'h00000000;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // pal_alarm_core
`default_nettype wire

/* File: tb/pal_meas_model.sv */
// measurement source model: one sample pulse per request
`timescale 1ns/1ps
`default_nettype none
module pal_meas_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sampleReq,
  input wire logic [15:0] sampleVal,
  output logic [15:0] measValue,
  output logic measValid
);
  // value toggles between samples so a stale value never looks valid
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      measValid <= 1'b0;
      measValue <= 16'h0;
    end else begin
      measValid <= sampleReq;
      measValue <= sampleReq ? sampleVal : ~measValue;
    end
  end
endmodule // pal_meas_model
`default_nettype wire

/* File: tb/pal_alarm_core_assertions.sv */
// port checker for the alarm block
`timescale 1ns/1ps
`default_nettype none
module pal_alarm_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic measValid,
  input wire logic [15:0] controlSetpoint,
  input wire logic [2:0] relayDrive,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire logic acc = psel && penable;
  wire logic rdAcc = acc && !pwrite;
  wire logic quiet = !measValid && !(acc && pwrite);
  a_ready_zero_wait: assert property (acc |-> pready) else $error("no ready");
  a_err_access_only: assert property (pslverr |-> acc) else $error("stray error");
  a_err_unmapped: assert property (acc && paddr > 8'h30 |-> pslverr) else $error("no error");
  a_write_only_zero: assert property (rdAcc && (paddr == 8'h20 || paddr == 8'h30)
    |-> prdata == 32'h0) else $error("write-only read");
  a_setpoint_mirror: assert property (rdAcc && paddr == 8'h18 && $stable(controlSetpoint)
    |-> prdata == {16'h0, $past(controlSetpoint)}) else $error("setpoint mirror");
  a_relay_hold: assert property (quiet |=> $stable(relayDrive)) else $error("relay moved");
  a_irq_hold: assert property (quiet |=> $stable(irq)) else $error("irq moved");
  a_relay_after_reset: assert property ($rose(reset_n) |-> relayDrive == 3'h7 && !irq)
    else $error("relay not safe after reset");
  c_ack: cover property (acc && pwrite && paddr == 8'h20);
  c_trip: cover property (measValid ##1 relayDrive != 3'h7);
  c_irq: cover property (irq);
endmodule // pal_alarm_checker
bind pal_alarm_core pal_alarm_checker i_pal_alarm_checker (.clk_sys(clk_sys), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .measValid(measValid),
  .controlSetpoint(controlSetpoint), .relayDrive(relayDrive), .irq(irq));
`default_nettype wire

/* File: tb/pal_alarm_core_test.sv */
// self-checking bench for the alarm block
`timescale 1ns/1ps
`default_nettype none
module pal_alarm_core_test;
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sampleReq = 1'b0, pready, pslverr, measValid, irq, errq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdq;
  logic [15:0] controlSetpoint = 16'h0, sampleVal = 16'h0, measValue;
  logic [2:0] relayDrive;
  int fails = 0, tests_run = 0;
  pal_alarm_core i_pal_alarm_core (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .measValue(measValue), .measValid(measValid),
    .controlSetpoint(controlSetpoint), .relayDrive(relayDrive), .irq(irq));
  pal_meas_model i_pal_meas_model (.clk_sys(clk_sys), .reset_n(reset_n), .sampleReq(sampleReq),
    .sampleVal(sampleVal), .measValue(measValue), .measValid(measValid));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdq = prdata;
    errq = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask
  task automatic pin(input logic [3:0] m, input logic [3:0] e);
    @(posedge clk_sys);
    chk({28'h0, {irq, relayDrive} & m}, {28'h0, e});
  endtask
  task automatic so(input logic [15:0] v, input logic [3:0] m, input logic [3:0] e);
    @(posedge clk_sys);
    sampleReq <= 1'b1;
    sampleVal <= v;
    @(posedge clk_sys);
    sampleReq <= 1'b0;
    @(posedge clk_sys);
    pin(m, e);
  endtask
  task automatic tDefaults();
    logic [31:0] dflt [6] = '{32'ha0409, 32'ha0401, 32'ha0401, 32'h1f4, 32'h1770, 32'h1f40};
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), dflt[i]);
    end
    rd(8'h1c, 32'h2710);
    pin(4'hf, 4'h7);
  endtask
  task automatic tFilter();
    repeat (4) so(16'h1f40, 4'h2, 4'h2);
    so(16'h1f40, 4'h6, 4'h4);
  endtask
  task automatic tInhib();
    wr(8'h00, 32'ha0009);
    wr(8'h04, 32'ha0001);
    wr(8'h08, 32'ha0001);
    wr(8'h20, 32'h10);
    rd(8'h24, 32'h722);
    so(16'h64, 4'h1, 4'h1);
    so(16'h1f5, 4'h1, 4'h1);
    so(16'h1f3, 4'h1, 4'h0);
    so(16'h257, 4'h1, 4'h0);
    so(16'h259, 4'h1, 4'h1);
    wr(8'h00, 32'ha0005);
    so(16'h64, 4'h1, 4'h0);
  endtask
  task automatic tLatch();
    wr(8'h08, 32'ha0031);
    wr(8'h30, 32'h7);
    so(16'h1f41, 4'hc, 4'h4);
    rd(8'h28, 32'h6);
    wr(8'h2c, 32'h4);
    pin(4'h8, 4'h8);
    wr(8'h2c, 32'h0);
    pin(4'h8, 4'h0);
    wr(8'h2c, 32'h4);
    wr(8'h30, 32'h4);
    pin(4'h8, 4'h0);
    so(16'h64, 4'h4, 4'h4);
    wr(8'h20, 32'h4);
    pin(4'h4, 4'h0);
  endtask
  task automatic tSource();
    controlSetpoint <= 16'h1b58;
    wr(8'h04, 32'ha0002);
    so(16'h384, 4'h2, 4'h0);
    wr(8'h04, 32'ha0003);
    so(16'h384, 4'h2, 4'h2);
    so(16'h332c, 4'h2, 4'h0);
    wr(8'h04, 32'ha0000);
    so(16'h332c, 4'h2, 4'h2);
    rd(8'h18, 32'h1b58);
  endtask
  task automatic tRegs();
    wr(8'h04, 32'h7f3f01);
    rd(8'h04, 32'h643201);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h10001);
    wr(8'h10, 32'hffff);
    rd(8'h10, 32'h2af8);
    rd(8'h20, 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, errq}, 32'h1);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    tDefaults();
    tFilter();
    tInhib();
    tLatch();
    tSource();
    tRegs();
    conclude();
  end
endmodule // pal_alarm_core_test
`default_nettype wire
